// File: verilog/vec_start_pkg.sv
`default_nettype none
package vec_start_pkg;
  // Register byte offsets
  localparam logic [7:0] START_TRIG_OFS = 8'h00;
  localparam logic [7:0] TASK_SEL_OFS = 8'h04;
  localparam logic [7:0] SCHED_SEL_OFS = 8'h08;
  localparam logic [7:0] REPEAT_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] TERMINATE_OFS = 8'h14;
  localparam int ADDR_W = 8;

  // Field positions
  localparam int SW_START_BIT = 1;
  localparam int TERMINATE_BIT = 1;
  localparam int FIELD_LSB = 4;
  localparam int FIELD_MSB = 7;
  localparam int FIELD_W = 4;
  localparam int BUSY_BIT = 0;
  localparam int LEFT_LSB = 8;
  localparam int LEFT_MSB = 11;

  // Reset values
  localparam logic [3:0] FIELD_RST = 4'h0;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // Schedule select code for a single task
  localparam logic [3:0] SCHED_SINGLE = 4'h0;
  localparam logic [3:0] REPEAT_NONE = 4'h0;
  localparam logic [3:0] ONE_PASS = 4'h1;

  typedef enum logic [3:0] {
    TASK_OUT_CTRL1,
    TASK_TRIG_GEN,
    TASK_IN_PROC1,
    TASK_IN_PHASE,
    TASK_IN_AXIS,
    TASK_CUR_CTRL,
    TASK_SIN_COS,
    TASK_OUT_AXIS,
    TASK_OUT_PHASE_SVM,
    TASK_OUT_CTRL2,
    TASK_IN_PROC2,
    TASK_OUT_PHASE_ICLARKE,
    TASK_ATAN,
    TASK_SQRT,
    TASK_RSVD_E,
    TASK_RSVD_F
  } task_code_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } run_state_t;
endpackage
`default_nettype wire

// File: verilog/vec_start_sched_ctrl.sv
// The APB slave port and the register offsets were decided locally.
`default_nettype none
module vec_start_sched_ctrl (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pass_done_i,
  output logic run_start_o,
  output logic [3:0] run_task_o,
  output logic [3:0] run_sched_o,
  output logic busy_o,
  output logic terminate_o
);

  logic [3:0] task_sel_ff;
  logic [3:0] nxt_task_sel;
  logic [3:0] sched_sel_ff;
  logic [3:0] nxt_sched_sel;
  logic [3:0] repeat_ff;
  logic [3:0] nxt_repeat;
  logic sw_start_ff;
  logic nxt_sw_start;
  logic terminate_ff;
  logic nxt_terminate;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  vec_start_pkg::run_state_t state_ff;
  vec_start_pkg::run_state_t nxt_state;
  logic [3:0] left_ff;
  logic [3:0] nxt_left;
  logic [3:0] run_task_ff;
  logic [3:0] nxt_run_task;
  logic [3:0] run_sched_ff;
  logic [3:0] nxt_run_sched;
  logic run_start_ff;
  logic nxt_run_start;
  logic busy_ff;
  logic nxt_busy;
  logic single_task;
  logic run_none;

  logic access;
  logic answer;
  logic wr_en;
  logic rd_en;
  logic [7:0] ofs;
  logic mapped;
  logic wr_start;
  logic wr_task;
  logic wr_sched;
  logic wr_repeat;
  logic wr_term;
  logic [31:0] task_word;
  logic [31:0] sched_word;
  logic [31:0] repeat_word;
  logic [31:0] status_word;

  // First access cycle answers, second commits
  assign answer = psel_i && penable_i && !pready_ff;
  assign access = psel_i && penable_i && pready_ff;
  assign wr_en = access && pwrite_i;
  assign rd_en = answer && !pwrite_i;
  assign ofs = paddr_i[vec_start_pkg::ADDR_W-1:0];

  always_comb begin
    case (ofs)
      vec_start_pkg::START_TRIG_OFS,
      vec_start_pkg::TASK_SEL_OFS,
      vec_start_pkg::SCHED_SEL_OFS,
      vec_start_pkg::REPEAT_OFS,
      vec_start_pkg::STATUS_OFS,
      vec_start_pkg::TERMINATE_OFS: mapped = (paddr_i[31:8] == 24'h000000);
      default: mapped = 1'b0;
    endcase
  end

  // Write strobes, one per writable register
  assign wr_start = wr_en && mapped &&
    (ofs == vec_start_pkg::START_TRIG_OFS);
  assign wr_task = wr_en && mapped &&
    (ofs == vec_start_pkg::TASK_SEL_OFS);
  assign wr_sched = wr_en && mapped &&
    (ofs == vec_start_pkg::SCHED_SEL_OFS);
  assign wr_repeat = wr_en && mapped &&
    (ofs == vec_start_pkg::REPEAT_OFS);
  assign wr_term = wr_en && mapped &&
    (ofs == vec_start_pkg::TERMINATE_OFS);

  // Read words, unused bits held at zero
  always_comb begin
    task_word = vec_start_pkg::DATA_ZERO;
    sched_word = vec_start_pkg::DATA_ZERO;
    repeat_word = vec_start_pkg::DATA_ZERO;
    status_word = vec_start_pkg::DATA_ZERO;
    task_word[vec_start_pkg::FIELD_MSB:vec_start_pkg::FIELD_LSB] =
      task_sel_ff;
    sched_word[vec_start_pkg::FIELD_MSB:vec_start_pkg::FIELD_LSB] =
      sched_sel_ff;
    repeat_word[vec_start_pkg::FIELD_MSB:vec_start_pkg::FIELD_LSB] =
      repeat_ff;
    status_word[vec_start_pkg::BUSY_BIT] = busy_ff;
    status_word[vec_start_pkg::FIELD_MSB:vec_start_pkg::FIELD_LSB] =
      run_task_ff;
    status_word[vec_start_pkg::LEFT_MSB:vec_start_pkg::LEFT_LSB] =
      left_ff;
  end

  // Bus slave and register file
  always_comb begin
    nxt_task_sel = task_sel_ff;
    nxt_sched_sel = sched_sel_ff;
    nxt_repeat = repeat_ff;
    nxt_sw_start = 1'b0;
    nxt_terminate = 1'b0;
    nxt_pready = answer;
    nxt_pslverr = answer && !mapped;
    nxt_prdata = vec_start_pkg::DATA_ZERO;
    if (rd_en && mapped) begin
      case (ofs)
        vec_start_pkg::TASK_SEL_OFS: nxt_prdata = task_word;
        vec_start_pkg::SCHED_SEL_OFS: nxt_prdata = sched_word;
        vec_start_pkg::REPEAT_OFS: nxt_prdata = repeat_word;
        vec_start_pkg::STATUS_OFS: nxt_prdata = status_word;
        default: nxt_prdata = vec_start_pkg::DATA_ZERO;
      endcase
    end
    if (wr_start) begin
      nxt_sw_start = pwdata_i[vec_start_pkg::SW_START_BIT];
    end
    if (wr_task) begin
      nxt_task_sel =
        pwdata_i[vec_start_pkg::FIELD_MSB:vec_start_pkg::FIELD_LSB];
    end
    if (wr_sched) begin
      nxt_sched_sel =
        pwdata_i[vec_start_pkg::FIELD_MSB:vec_start_pkg::FIELD_LSB];
    end
    if (wr_repeat) begin
      nxt_repeat =
        pwdata_i[vec_start_pkg::FIELD_MSB:vec_start_pkg::FIELD_LSB];
    end
    if (wr_term) begin
      nxt_terminate = pwdata_i[vec_start_pkg::TERMINATE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      task_sel_ff <= vec_start_pkg::FIELD_RST;
      sched_sel_ff <= vec_start_pkg::FIELD_RST;
      repeat_ff <= vec_start_pkg::FIELD_RST;
      sw_start_ff <= 1'b0;
      terminate_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= vec_start_pkg::DATA_ZERO;
    end else begin
      task_sel_ff <= nxt_task_sel;
      sched_sel_ff <= nxt_sched_sel;
      repeat_ff <= nxt_repeat;
      sw_start_ff <= nxt_sw_start;
      terminate_ff <= nxt_terminate;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // Run mode decode
  assign single_task =
    (sched_sel_ff == vec_start_pkg::SCHED_SINGLE);
  assign run_none =
    (repeat_ff == vec_start_pkg::REPEAT_NONE);

  // Run sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_left = left_ff;
    nxt_run_task = run_task_ff;
    nxt_run_sched = run_sched_ff;
    nxt_run_start = 1'b0;
    case (state_ff)
      vec_start_pkg::ST_IDLE: begin
        if (sw_start_ff) begin
          nxt_run_task = task_sel_ff;
          nxt_run_sched = sched_sel_ff;
          if (single_task) begin
            nxt_left = vec_start_pkg::ONE_PASS;
            nxt_state = vec_start_pkg::ST_ISSUE;
          end else if (!run_none) begin
            nxt_left = repeat_ff;
            nxt_state = vec_start_pkg::ST_ISSUE;
          end else begin
            nxt_state = vec_start_pkg::ST_IDLE;
          end
        end
      end
      vec_start_pkg::ST_ISSUE: begin
        nxt_run_start = 1'b1;
        nxt_state = vec_start_pkg::ST_WAIT;
      end
      vec_start_pkg::ST_WAIT: begin
        if (pass_done_i) begin
          nxt_left = left_ff - vec_start_pkg::ONE_PASS;
          if (left_ff == vec_start_pkg::ONE_PASS) begin
            nxt_state = vec_start_pkg::ST_IDLE;
          end else begin
            nxt_state = vec_start_pkg::ST_ISSUE;
          end
        end
      end
      default: nxt_state = vec_start_pkg::ST_IDLE;
    endcase
    if (terminate_ff) begin
      nxt_state = vec_start_pkg::ST_IDLE;
      nxt_left = vec_start_pkg::FIELD_RST;
      nxt_run_start = 1'b0;
    end
    nxt_busy = (nxt_state != vec_start_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= vec_start_pkg::ST_IDLE;
      left_ff <= vec_start_pkg::FIELD_RST;
      run_task_ff <= vec_start_pkg::FIELD_RST;
      run_sched_ff <= vec_start_pkg::FIELD_RST;
      run_start_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      left_ff <= nxt_left;
      run_task_ff <= nxt_run_task;
      run_sched_ff <= nxt_run_sched;
      run_start_ff <= nxt_run_start;
      busy_ff <= nxt_busy;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign run_start_o = run_start_ff;
  assign run_task_o = run_task_ff;
  assign run_sched_o = run_sched_ff;
  assign busy_o = busy_ff;
  assign terminate_o = terminate_ff;

endmodule // vec_start_sched_ctrl
`default_nettype wire

// File: verif/vec_start_sched_ctrl_sva.sv
`default_nettype none
module vec_start_sched_ctrl_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pass_done_i,
  input wire logic run_start_o,
  input wire logic [3:0] run_task_o,
  input wire logic busy_o,
  input wire logic terminate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic acc;
  logic wr0;
  assign acc = psel_i && penable_i && pready_o;
  assign wr0 = acc && pwrite_i && paddr_i[7:0] == 8'h00;
  sequence s_run; busy_o ##1 run_start_o; endsequence
  sequence s_term; terminate_o ##1 !busy_o; endsequence
  property p_start; $rose(busy_o) |-> $past(wr0 && pwdata_i[1], 2); endproperty
  a_start: assert property (p_start)
    else $error("busy without start");
  property p_zero; wr0 && !pwdata_i[1] && !busy_o |-> ##2 !busy_o; endproperty
  a_zero: assert property (p_zero)
    else $error("zero write started");
  property p_rd0;
    acc && !pwrite_i && (paddr_i[7:0] == 8'h00 || paddr_i[7:0] == 8'h14)
      |-> prdata_o == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0)
    else $error("trigger read nonzero");
  property p_first; $rose(busy_o) |-> s_run; endproperty
  a_first: assert property (p_first)
    else $error("no first pass");
  property p_tsk; run_start_o |-> $stable(run_task_o); endproperty
  a_tsk: assert property (p_tsk)
    else $error("task moved");
  property p_pass; busy_o && pass_done_i |=> (!busy_o or ##1 run_start_o);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass follow-up wrong");
  property p_rsv;
    acc && !pwrite_i |-> prdata_o[31:12] == 20'h0 && prdata_o[3:1] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("unused bits set");
  property p_term;
    acc && pwrite_i && paddr_i[7:0] == 8'h14 && pwdata_i[1] |=> s_term;
  endproperty
  a_term: assert property (p_term)
    else $error("terminate failed");
endmodule // vec_start_sched_ctrl_sva
bind vec_start_sched_ctrl vec_start_sched_ctrl_sva
  vec_start_sched_ctrl_sva_i (.*);
`default_nettype wire

// File: verif/vec_start_sched_ctrl_tb.sv
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module vec_start_sched_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic pass_done_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic [3:0] run_task_o;
  logic [3:0] run_sched_o;
  logic pready_o, pslverr_o, run_start_o, busy_o, terminate_o, er;
  int error_cnt = 0;
  int checks_done = 0;
  always #2 clk_i = ~clk_i;
  vec_start_sched_ctrl vec_start_sched_ctrl_i (.*);
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 20) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {24'h0, a};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    tmo(n);
  endtask
  task automatic run_chk(input logic [3:0] tk, input logic [3:0] sc, int np);
    int n;
    for (int p = 0; p < np; p++) begin
      n = 0;
      @(negedge clk_i);
      while (run_start_o !== 1'b1 && n < 20) begin
        @(negedge clk_i);
        n++;
      end
      tmo(n);
      `CHK(run_task_o, tk)
      `CHK(run_sched_o, sc)
      @(posedge clk_i);
      pass_done_i <= 1'b1;
      @(posedge clk_i);
      pass_done_i <= 1'b0;
    end
    repeat (2) @(negedge clk_i);
    `CHK(busy_o, 1'b0)
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 8'h18, 32'h0);
    `CHK(er, 1'b1)
    for (int i = 0; i < 16; i++) begin
      for (int a = 4; a < 16; a += 4) begin
        apb(1'b1, 8'(a), {24'hffffff, 4'(i), 4'h0});
        apb(1'b0, 8'(a), 32'h0);
        `CHK(rd, {24'h0, 4'(i), 4'h0})
      end
    end
    apb(1'b1, 8'h04, 32'h50);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    run_chk(4'h5, 4'h0, 1);
    apb(1'b1, 8'h08, 32'h30);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0)
    @(negedge clk_i);
    `CHK(busy_o, 1'b0)
    apb(1'b1, 8'h0c, 32'h20);
    apb(1'b1, 8'h04, 32'hd0);
    apb(1'b1, 8'h00, 32'h2);
    run_chk(4'hd, 4'h3, 2);
    apb(1'b1, 8'h0c, 32'hf0);
    apb(1'b1, 8'h00, 32'h0);
    repeat (3) @(negedge clk_i);
    `CHK(busy_o, 1'b0)
    apb(1'b1, 8'h00, 32'h2);
    repeat (3) @(negedge clk_i);
    `CHK(busy_o, 1'b1)
    apb(1'b1, 8'h14, 32'h2);
    @(negedge clk_i);
    `CHK(terminate_o, 1'b1)
    repeat (2) @(negedge clk_i);
    `CHK(busy_o, 1'b0)
    test_done();
  end
endmodule // vec_start_sched_ctrl_tb
`default_nettype wire
